// ==== timer_params.svh ====
// Constants shared by the three channel interval timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Register offsets
`define REG_CTRL0        4'h0
`define REG_CTRL1        4'h1
`define REG_CTRL2        4'h2
`define REG_LOAD0        4'h4
`define REG_LOAD1        4'h5
`define REG_LOAD2        4'h6
`define REG_COUNT0       4'h8
`define REG_COUNT1       4'h9
`define REG_COUNT2       4'hA
`define REG_STATUS       4'hC
`define REG_MASK         4'hD
`define REG_TRIG         4'hE
`define REG_LEVEL        4'hF
`define REG_STRIDE       2'h1

// Control register fields
`define CTRL_MODE_LSB    0
`define CTRL_MODE_W      3
`define CTRL_BCD_BIT     3
`define CTRL_EXTCLK_BIT  4
`define CTRL_W           5
`define CTRL_RESET       5'h00
`define MASK_RESET       3'h0
`define COUNT_W          16
`define NUM_CH           3

// Reference and limit rates, in kHz
`define REF_CLK_KHZ      1382.4
`define EXT_CLK_MAX_KHZ  2000.0
`define CORE_CLK_KHZ     10000.0
`define ZERO16           16'h0000
`define ONE16            16'h0001
`define TWO16            16'h0002

`endif

// ==== timer_pkg.sv ====
// Types shared by the interval timer blocks
package timer_pkg;
  typedef enum logic [2:0] {
    MODE_TC_INT    = 3'h0,
    MODE_ONE_SHOT  = 3'h1,
    MODE_RATE      = 3'h2,
    MODE_SQUARE    = 3'h3,
    MODE_SW_STROBE = 3'h4,
    MODE_HW_STROBE = 3'h5
  } mode_t;

  typedef struct packed {
    logic  ext_clk;
    logic  bcd;
    mode_t mode;
  } ctrl_t;

  typedef struct packed {
    logic clk_tick;
    logic gate;
    logic gate_rise;
    logic load;
    logic sw_trig;
  } chan_in_t;
endpackage

// ==== timer_channel.sv ====
// One 16-bit down counting interval timer channel
`include "timer_params.svh"
module timer_channel (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  // Control
  input  wire timer_pkg::ctrl_t          ctrl,
  input  wire logic [`COUNT_W-1:0]       reload,
  input  wire timer_pkg::chan_in_t       cin,
  // Status
  output logic [`COUNT_W-1:0]            o_count,
  output logic                           o_out,
  output logic                           o_tc
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } st_t;

  st_t                 st;
  st_t                 next_st;
  logic [`COUNT_W-1:0] count;
  logic [`COUNT_W-1:0] next_count;
  logic                out;
  logic                next_out;
  logic                tc;
  logic                next_tc;
  logic [`COUNT_W-1:0] dec;
  logic [`COUNT_W-1:0] step;
  logic                start;
  logic                zero_next;

  // One step down, binary or per BCD digit
  function automatic logic [`COUNT_W-1:0] bcd_dec(input logic [`COUNT_W-1:0] v, input logic [`COUNT_W-1:0] by);
    logic [`COUNT_W-1:0] r;
    r = v;
    for (int k = 0; k < 2; k++) begin
      if (by > `ONE16 || k == 0) begin
        for (int d = 0; d < 4; d++) begin
          if (r[d*4 +: 4] != 4'h0) begin
            r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
            break;
          end
          r[d*4 +: 4] = 4'h9;
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    // Trigger-started modes ignore a load and start only on their trigger
    start = (cin.load && ctrl.mode != timer_pkg::MODE_ONE_SHOT && ctrl.mode != timer_pkg::MODE_HW_STROBE)
      || ((ctrl.mode == timer_pkg::MODE_ONE_SHOT) && (cin.sw_trig || cin.gate_rise))
      || ((ctrl.mode == timer_pkg::MODE_HW_STROBE) && cin.gate_rise);
    step = (ctrl.mode == timer_pkg::MODE_SQUARE) ? `TWO16 : `ONE16;
    dec  = ctrl.bcd ? bcd_dec(count, step) : count - step;
    zero_next = (count <= step);
    next_st    = st;
    next_count = count;
    next_out   = out;
    next_tc    = 1'b0;
    if (start) begin
      next_st    = ST_RUN;
      next_count = reload;
      case (ctrl.mode)
        timer_pkg::MODE_TC_INT:   next_out = 1'b0;
        timer_pkg::MODE_ONE_SHOT: next_out = 1'b0;
        default:                  next_out = 1'b1;
      endcase
    end else if (st != ST_IDLE && cin.clk_tick && (cin.gate || ctrl.mode == timer_pkg::MODE_ONE_SHOT
                 || ctrl.mode == timer_pkg::MODE_HW_STROBE)) begin
      case (ctrl.mode)
        timer_pkg::MODE_RATE: begin
          // Low tick holds count one, so the period spans exactly N ticks
          if (!out) begin
            next_out   = 1'b1;
            next_count = reload;
          end else if (count <= `TWO16) begin
            next_out   = 1'b0;
            next_count = dec;
            next_tc    = 1'b1;
          end else begin
            next_count = dec;
          end
        end
        timer_pkg::MODE_SQUARE: begin
          if (zero_next) begin
            next_out   = ~out;
            next_count = reload;
            next_tc    = out;
          end else begin
            next_count = dec;
          end
        end
        timer_pkg::MODE_SW_STROBE, timer_pkg::MODE_HW_STROBE: begin
          if (!out) begin
            next_out = 1'b1;
            next_st  = ST_DONE;
          end else if (st == ST_RUN) begin
            next_count = dec;
            if (count == `ONE16) begin
              next_out = 1'b0;
              next_tc  = 1'b1;
            end
          end
        end
        default: begin
          next_count = dec;
          if (st == ST_RUN && count == `ONE16) begin
            next_out = 1'b1;
            next_tc  = 1'b1;
            next_st  = ST_DONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st    <= ST_IDLE;
      count <= `ZERO16;
      out   <= 1'b1;
      tc    <= 1'b0;
    end else if (ce) begin
      st    <= next_st;
      count <= next_count;
      out   <= next_out;
      tc    <= next_tc;
    end
  end

  assign o_count = count;
  assign o_out   = out;
  assign o_tc    = tc;
endmodule // timer_channel

// ==== interval_timer_unit.sv ====
// Three channel interval timer with register port and interrupt status
//
// Implementation choices: the placing of the registers and the strobed register port.
`include "timer_params.svh"
module interval_timer_unit (
  // Clock, reset, enable
  input  wire logic                   I_CORE_CLK,
  input  wire logic                   I_NRST,
  input  wire logic                   I_CE,
  // Register port
  input  wire logic [3:0]             I_ADDR,
  input  wire logic [15:0]            I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  output logic [15:0]                 O_RDATA,
  // Channel pins
  input  wire logic [`NUM_CH-1:0]     I_TMR_CLK,
  input  wire logic [`NUM_CH-1:0]     I_TMR_GATE,
  output logic [`NUM_CH-1:0]          O_TMR_OUT,
  // Interrupts
  output logic [`NUM_CH-1:0]          O_TMR_IRQ,
  output logic                        O_IRQ
);
  timer_pkg::ctrl_t    ctrl      [`NUM_CH];
  timer_pkg::ctrl_t    next_ctrl [`NUM_CH];
  logic [`COUNT_W-1:0] reload      [`NUM_CH];
  logic [`COUNT_W-1:0] next_reload [`NUM_CH];
  logic [`COUNT_W-1:0] count       [`NUM_CH];
  logic [`NUM_CH-1:0]  load;
  logic [`NUM_CH-1:0]  next_load;
  logic [`NUM_CH-1:0]  sw_trig;
  logic [`NUM_CH-1:0]  next_sw_trig;
  logic [`NUM_CH-1:0]  tc;
  logic [`NUM_CH-1:0]  chan_out;
  logic [`NUM_CH-1:0]  status;
  logic [`NUM_CH-1:0]  next_status;
  logic [`NUM_CH-1:0]  mask;
  logic [`NUM_CH-1:0]  next_mask;
  logic [15:0]         rdata;
  logic [15:0]         next_rdata;
  // Clock and gate edge detection
  logic [`NUM_CH-1:0]  ext_prev;
  logic [`NUM_CH-1:0]  gate_prev;
  logic [`NUM_CH-1:0]  ext_rise;
  logic [`NUM_CH-1:0]  gate_rise;
  logic [`NUM_CH-1:0]  ref_tick_v;
  logic [`NUM_CH-1:0]  tick;
  // Reference clock: fractional accumulator of REF/CORE
  localparam logic [15:0] REF_INC = 16'(int'(`REF_CLK_KHZ * 65536.0 / `CORE_CLK_KHZ));
  logic [15:0]         ref_acc;
  logic [15:0]         next_ref_acc;
  logic                ref_tick;
  logic                next_ref_tick;

  always_comb begin
    {next_ref_tick, next_ref_acc} = {1'b0, ref_acc} + {1'b0, REF_INC};
    ref_tick_v = {`NUM_CH{ref_tick}};
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ref_acc  <= 16'h0000;
      ref_tick <= 1'b0;
      ext_prev <= 3'h0;
      gate_prev <= 3'h7;
    end else if (I_CE) begin
      ref_acc  <= next_ref_acc;
      ref_tick <= next_ref_tick;
      ext_prev <= I_TMR_CLK;
      gate_prev <= I_TMR_GATE;
    end
  end

  always_comb begin
    ext_rise  = I_TMR_CLK & ~ext_prev;
    gate_rise = I_TMR_GATE & ~gate_prev;
    for (int c = 0; c < `NUM_CH; c++) begin
      tick[c] = ctrl[c].ext_clk ? ext_rise[c] : ref_tick_v[c];
    end
  end

  // Register writes
  always_comb begin
    for (int c = 0; c < `NUM_CH; c++) begin
      next_ctrl[c]   = ctrl[c];
      next_reload[c] = reload[c];
    end
    next_load    = 3'h0;
    next_sw_trig = 3'h0;
    next_mask    = mask;
    next_status  = status | tc;                                          // Set wins over clear
    if (I_WR) begin
      if (I_ADDR >= `REG_CTRL0 && I_ADDR <= `REG_CTRL2) begin
        next_ctrl[I_ADDR[1:0]] = timer_pkg::ctrl_t'(I_WDATA[`CTRL_W-1:0]);
      end else if (I_ADDR >= `REG_LOAD0 && I_ADDR <= `REG_LOAD2) begin
        next_reload[I_ADDR[1:0]] = I_WDATA;
        next_load[I_ADDR[1:0]]   = 1'b1;
      end else if (I_ADDR == `REG_STATUS) begin
        next_status = (status & ~I_WDATA[`NUM_CH-1:0]) | tc;
      end else if (I_ADDR == `REG_MASK) begin
        next_mask = I_WDATA[`NUM_CH-1:0];
      end else if (I_ADDR == `REG_TRIG) begin
        next_sw_trig = I_WDATA[`NUM_CH-1:0];
      end
    end
  end

  // Register reads, count sampled live
  always_comb begin
    next_rdata = 16'h0000;
    if (I_RD) begin
      if (I_ADDR >= `REG_CTRL0 && I_ADDR <= `REG_CTRL2 && I_ADDR[1:0] != 2'h3) begin
        next_rdata = {11'h000, ctrl[I_ADDR[1:0]]};
      end else if (I_ADDR >= `REG_LOAD0 && I_ADDR <= `REG_LOAD2) begin
        next_rdata = reload[I_ADDR[1:0]];
      end else if (I_ADDR >= `REG_COUNT0 && I_ADDR <= `REG_COUNT2) begin
        next_rdata = count[I_ADDR[1:0]];
      end else if (I_ADDR == `REG_STATUS) begin
        next_rdata = {13'h0000, status};
      end else if (I_ADDR == `REG_MASK) begin
        next_rdata = {13'h0000, mask};
      end else if (I_ADDR == `REG_LEVEL) begin
        next_rdata = {10'h000, I_TMR_GATE, chan_out};
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      for (int c = 0; c < `NUM_CH; c++) begin
        ctrl[c]   <= timer_pkg::ctrl_t'(`CTRL_RESET);
        reload[c] <= `ZERO16;
      end
      load    <= 3'h0;
      sw_trig <= 3'h0;
      status  <= 3'h0;
      mask    <= `MASK_RESET;
      rdata   <= 16'h0000;
    end else if (I_CE) begin
      for (int c = 0; c < `NUM_CH; c++) begin
        ctrl[c]   <= next_ctrl[c];
        reload[c] <= next_reload[c];
      end
      load    <= next_load;
      sw_trig <= next_sw_trig;
      status  <= next_status;
      mask    <= next_mask;
      rdata   <= next_rdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g++) begin : g_ch
      timer_channel u_ch (
        .clk     (I_CORE_CLK),
        .nrst    (I_NRST),
        .ce      (I_CE),
        .ctrl    (ctrl[g]),
        .reload  (reload[g]),
        .cin     ({tick[g], I_TMR_GATE[g], gate_rise[g], load[g], sw_trig[g]}),
        .o_count (count[g]),
        .o_out   (chan_out[g]),
        .o_tc    (tc[g])
      );
    end
  endgenerate

  assign O_RDATA   = rdata;
  assign O_TMR_OUT = chan_out;
  assign O_TMR_IRQ = chan_out;
  assign O_IRQ     = |(status & mask);
endmodule // interval_timer_unit

// ==== timer_unit_assertions.sv ====
// Concurrent checks on the interval timer unit ports
module timer_unit_checker (
  // Clock and reset
  input wire logic        I_CORE_CLK,
  input wire logic        I_NRST,
  input wire logic        I_CE,
  // Register port
  input wire logic [3:0]  I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [15:0] O_RDATA,
  // Channel pins and interrupts
  input wire logic [2:0]  I_TMR_CLK,
  input wire logic [2:0]  I_TMR_GATE,
  input wire logic [2:0]  O_TMR_OUT,
  input wire logic [2:0]  O_TMR_IRQ,
  input wire logic        O_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_NRST);
  logic [2:0] m0;
  logic [2:0] m1;
  logic       w;
  assign w = I_WR && I_CE;
  // Mode of channels 0 and 1 as last written
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      m0 <= 3'h0;
      m1 <= 3'h0;
    end else begin
      if (w && I_ADDR == 4'h0) m0 <= I_WDATA[2:0];
      if (w && I_ADDR == 4'h1) m1 <= I_WDATA[2:0];
    end
  end
  property p_irq_line; O_TMR_IRQ == O_TMR_OUT; endproperty
  a_irq_line: assert property (p_irq_line) else $error("irq line differs from output");
  property p_rd_idle; !I_RD && I_CE |=> O_RDATA == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_freeze; !I_CE |=> $stable(O_TMR_OUT); endproperty
  a_freeze: assert property (p_freeze) else $error("output moved while halted");
  property p_rate; $fell(O_TMR_OUT[0]) && m0 == 3'h2 |-> ##[1:9] (O_TMR_OUT[0] || m0 != 3'h2); endproperty
  a_rate: assert property (p_rate) else $error("rate pulse too long");
  property p_sqr; $fell(O_TMR_OUT[0]) && m0 == 3'h3 |-> (!O_TMR_OUT[0] || m0 != 3'h3) [*5]; endproperty
  a_sqr: assert property (p_sqr) else $error("square low half too short");
  property p_ctrl;
    w && I_ADDR == 4'h0 ##1 !I_WR ##1 I_RD && I_CE && I_ADDR == 4'h0 |=> O_RDATA[4:0] == $past(I_WDATA[4:0], 3);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_tc; m1 == 3'h0 && w && I_ADDR == 4'h5 && I_WDATA != 16'h0000 |-> ##[1:3] !O_TMR_OUT[1]; endproperty
  a_tc: assert property (p_tc) else $error("output not low after load");
  property p_trig; m1 == 3'h1 && w && I_ADDR == 4'hE && I_WDATA[1] |-> ##[1:3] !O_TMR_OUT[1]; endproperty
  a_trig: assert property (p_trig) else $error("one-shot not started");
endmodule // timer_unit_checker

bind interval_timer_unit timer_unit_checker u_chk (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_CE(I_CE),
  .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_TMR_CLK(I_TMR_CLK),
  .I_TMR_GATE(I_TMR_GATE), .O_TMR_OUT(O_TMR_OUT), .O_TMR_IRQ(O_TMR_IRQ), .O_IRQ(O_IRQ));

// ==== cpu_bus_model.sv ====
// Local bus master standing in for the on-board processor
module cpu_bus_model (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic [3:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd,
  input  wire logic [15:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_addr = 4'h0;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Data lines show the inverse once the strobe is gone
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge clk);
    o_rd <= 1'b0;
    @(negedge clk);
    d = i_rdata;
  endtask
endmodule // cpu_bus_model

// ==== interval_timer_unit_bench.sv ====
// Self-checking bench for the three channel interval timer
`include "timer_params.svh"
module interval_timer_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [2:0]  tclk = 3'h0;
  logic [2:0]  gate = 3'h7;
  logic [2:0]  tout;
  logic        irq;
  logic [15:0] d;
  logic        saw;
  int          mismatches;
  int          num_checks;
  int          cycles;
  int          lows;
  int          first;
  int          last;
  interval_timer_unit u_dut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TMR_CLK(tclk), .I_TMR_GATE(gate), .O_TMR_OUT(tout),
    .O_TMR_IRQ(), .O_IRQ(irq));
  cpu_bus_model u_cpu (.clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
  always #50 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] v;
    u_cpu.rd(a, v);
    chk(v, exp);
  endtask
  // One external clock period of six core cycles
  task automatic tick;
    @(posedge clk);
    tclk <= 3'h7;
    repeat (3) @(posedge clk);
    tclk <= 3'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  // Counts the ticks that end with the channel output low
  task automatic run(input int ch, input int n);
    lows = 0;
    for (int i = 0; i < n; i++) begin
      tick();
      if (tout[ch] === 1'b0) begin
        if (lows == 0) first = i;
        last = i;
        lows++;
      end
    end
  endtask
  task automatic go(input logic [3:0] c, input logic [15:0] m, input logic [3:0] l, input logic [15:0] n);
    u_cpu.wr(c, m);
    u_cpu.wr(l, n);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({13'h0, tout}, 16'h0007);
    rdchk(`REG_CTRL0, 16'h0000);
    rdchk(`REG_MASK, 16'h0000);
    rdchk(4'h3, 16'h0000);
    u_cpu.wr(`REG_CTRL0, 16'h0012);
    rdchk(`REG_CTRL0, 16'h0012);
    u_cpu.wr(`REG_LOAD0, 16'h0004);
    run(0, 12);
    chk(16'(lows), 16'h0003);
    chk(16'(last - first), 16'h0008);
    go(`REG_CTRL0, 16'h0013, `REG_LOAD0, 16'h0004);
    run(0, 8);
    chk(16'(lows), 16'h0004);
    u_cpu.wr(`REG_MASK, 16'h0002);
    go(`REG_CTRL1, 16'h0010, `REG_LOAD1, 16'h0003);
    repeat (3) @(negedge clk);
    chk(16'(tout[1]), 16'h0000);
    tick();
    rdchk(`REG_COUNT1, 16'h0002);
    run(1, 3);
    chk(16'(tout[1]), 16'h0001);
    u_cpu.rd(`REG_STATUS, d);
    chk(16'(d[1]), 16'h0001);
    chk(16'(irq), 16'h0001);
    u_cpu.wr(`REG_MASK, 16'h0000);
    repeat (2) @(negedge clk);
    chk(16'(irq), 16'h0000);
    u_cpu.wr(`REG_MASK, 16'h0002);
    u_cpu.wr(`REG_STATUS, 16'h0002);
    repeat (2) @(negedge clk);
    chk(16'(irq), 16'h0000);
    go(`REG_CTRL1, 16'h0011, `REG_LOAD1, 16'h0003);
    u_cpu.wr(`REG_TRIG, 16'h0002);
    tick();
    u_cpu.wr(`REG_TRIG, 16'h0002);
    run(1, 2);
    chk(16'(tout[1]), 16'h0000);
    run(1, 2);
    chk(16'(tout[1]), 16'h0001);
    go(`REG_CTRL2, 16'h0014, `REG_LOAD2, 16'h0002);
    @(negedge clk);
    chk(16'(tout[2]), 16'h0001);
    run(2, 6);
    chk(16'(lows), 16'h0001);
    @(posedge clk);
    gate[2] <= 1'b0;
    go(`REG_CTRL2, 16'h0015, `REG_LOAD2, 16'h0003);
    @(posedge clk);
    gate[2] <= 1'b1;
    run(2, 8);
    chk(16'(lows), 16'h0001);
    @(posedge clk);
    gate[0] <= 1'b0;
    go(`REG_CTRL0, 16'h0010, `REG_LOAD0, 16'h0009);
    run(0, 3);
    rdchk(`REG_COUNT0, 16'h0009);
    @(posedge clk);
    gate[0] <= 1'b1;
    run(0, 2);
    rdchk(`REG_COUNT0, 16'h0007);
    go(`REG_CTRL0, 16'h0018, `REG_LOAD0, 16'h0010);
    tick();
    rdchk(`REG_COUNT0, 16'h0009);
    @(posedge clk);
    ce <= 1'b0;
    tick();
    @(posedge clk);
    ce <= 1'b1;
    rdchk(`REG_COUNT0, 16'h0009);
    go(`REG_CTRL0, 16'h0002, `REG_LOAD0, 16'h0002);
    saw = 1'b0;
    repeat (60) begin
      @(negedge clk);
      if (tout[0] === 1'b0) saw = 1'b1;
    end
    chk(16'(saw), 16'h0001);
    complete_run();
  end
endmodule // interval_timer_unit_bench
